// ===== ycrgb_pkg.sv
package ycrgb_pkg;

   // ****************************************************************
   // Widths and depths
   // ****************************************************************
   localparam int IN_W      = 10;
   localparam int OUT_W     = 10;
   localparam int TERM_W    = 16;
   localparam int SUM_W     = 18;
   localparam int TBL_DEPTH = 1024;
   localparam int N_TERMS   = 5;
   localparam int BUF_DEPTH = 2;
   localparam int CNT_W     = 2;

   // ****************************************************************
   // Fixed point: terms carry FRAC_W fraction bits
   // ****************************************************************
   localparam int FRAC_W  = 4;
   localparam int COEF_SH = 12;
   localparam int COEF_W  = 14;
   localparam int MILLI   = 1000;

   localparam int LUMA_OFF   = 16;
   localparam int CHROMA_OFF = 128;

   localparam logic [OUT_W-1:0]        OUT_MAX = '1;
   localparam logic signed [SUM_W-1:0] SAT_HI  = SUM_W'(2 ** OUT_W - 1);

   typedef enum {SRC_Y, SRC_CR, SRC_CB} ycrgb_src_e;

   // Term order: luma, red-diff for red, red-diff for green,
   // blue-diff for green, blue-diff for blue
   localparam int T_LUMA = 0;
   localparam int T_CR_R = 1;
   localparam int T_CR_G = 2;
   localparam int T_CB_G = 3;
   localparam int T_CB_B = 4;

   localparam ycrgb_src_e TERM_SRC [N_TERMS] = '{SRC_Y, SRC_CR, SRC_CR, SRC_CB, SRC_CB};
   localparam int TERM_COEF_MILLI [N_TERMS] = '{1164, 1596, 813, 392, 2017};
   localparam int TERM_OFF [N_TERMS] =
      '{LUMA_OFF, CHROMA_OFF, CHROMA_OFF, CHROMA_OFF, CHROMA_OFF};

   function automatic int coef_q(input int milli);
      return (milli * (2 ** COEF_SH) + MILLI / 2) / MILLI;
   endfunction

   // Sign-magnitude product, truncated toward zero, same as the multiplier path
   function automatic logic signed [TERM_W-1:0] term_value(input int code, input int milli,
                                                           input int off);
      int d;
      int mag;
      int v;
      d   = code - off;
      mag = (d < 0) ? -d : d;
      v   = (mag * coef_q(milli)) >>> (COEF_SH - FRAC_W);
      return TERM_W'((d < 0) ? -v : v);
   endfunction

endpackage

// ===== ycrgb_term_rom.sv
`timescale 1ns/100ps
module ycrgb_term_rom #(
   parameter int COEF_MILLI = 1000,
   parameter int OFFSET     = 0
) (
   input  wire logic [ycrgb_pkg::IN_W-1:0]          addr_i,
   output logic signed [ycrgb_pkg::TERM_W-1:0]      data_o
);

   logic signed [ycrgb_pkg::TERM_W-1:0] rom [ycrgb_pkg::TBL_DEPTH];

   // ****************************************************************
   // Constant table, one entry per input code
   // ****************************************************************
   for (genvar g = 0; g < ycrgb_pkg::TBL_DEPTH; g++) begin : g_ent
      assign rom[g] = ycrgb_pkg::term_value(g, COEF_MILLI, OFFSET);
   end

   assign data_o = rom[addr_i];

endmodule // ycrgb_term_rom

// ===== ycrgb_converter.sv
`timescale 1ns/100ps
module ycrgb_converter #(
   parameter bit USE_LUT  = 1'b1,
   parameter bit USE_TWOS = 1'b1
) (
   input  wire logic                        core_clk_i,
   input  wire logic                        srst_i,
   input  wire logic                        in_valid_i,
   output logic                             in_ready_o,
   input  wire logic [ycrgb_pkg::IN_W-1:0]  luma_i,
   input  wire logic [ycrgb_pkg::IN_W-1:0]  cb_i,
   input  wire logic [ycrgb_pkg::IN_W-1:0]  cr_i,
   output logic                             out_valid_o,
   input  wire logic                        out_ready_i,
   output logic [ycrgb_pkg::OUT_W-1:0]      red_o,
   output logic [ycrgb_pkg::OUT_W-1:0]      green_o,
   output logic [ycrgb_pkg::OUT_W-1:0]      blue_o
);

   localparam int IN_W   = ycrgb_pkg::IN_W;
   localparam int OUT_W  = ycrgb_pkg::OUT_W;
   localparam int TERM_W = ycrgb_pkg::TERM_W;
   localparam int SUM_W  = ycrgb_pkg::SUM_W;
   localparam int MAG_W  = IN_W + 1;
   localparam int DIFF_W = IN_W + 2;
   localparam int PROD_W = MAG_W + ycrgb_pkg::COEF_W;
   localparam int SH     = ycrgb_pkg::COEF_SH - ycrgb_pkg::FRAC_W;
   localparam logic [ycrgb_pkg::CNT_W-1:0] FULL = ycrgb_pkg::CNT_W'(ycrgb_pkg::BUF_DEPTH);
   localparam logic [ycrgb_pkg::CNT_W-1:0] ONE  = ycrgb_pkg::CNT_W'(1);
   localparam logic [ycrgb_pkg::CNT_W-1:0] ZERO = '0;

   // ****************************************************************
   // Input register stage
   // ****************************************************************
   logic                 in_ready_q, in_ready_d;
   logic                 s1_vld_q, s1_vld_d;
   logic [IN_W-1:0]      y_q, y_d;
   logic [IN_W-1:0]      cb_q, cb_d;
   logic [IN_W-1:0]      cr_q, cr_d;
   logic                 in_acc;
   logic                 push;
   logic                 pop;

   logic [ycrgb_pkg::CNT_W-1:0] fcnt_q, fcnt_d;

   assign in_acc = in_valid_i & in_ready_q;
   assign push   = s1_vld_q & (fcnt_q != FULL);
   assign pop    = out_valid_o & out_ready_i;

   always_comb begin
      y_d      = y_q;
      cb_d     = cb_q;
      cr_d     = cr_q;
      s1_vld_d = s1_vld_q & ~push;
      if (in_acc) begin
         y_d      = luma_i;
         cb_d     = cb_i;
         cr_d     = cr_i;
         s1_vld_d = 1'b1;
      end
      // Ready is a flop fed from the next state, so it drops only once the stage plus
      // the two-entry buffer are full; while it is high there is always room for the word taken this cycle
      in_ready_d = ~(s1_vld_d & (fcnt_d == FULL));
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         in_ready_q <= 1'b0;
         s1_vld_q   <= 1'b0;
         y_q        <= '0;
         cb_q       <= '0;
         cr_q       <= '0;
      end else begin
         in_ready_q <= in_ready_d;
         s1_vld_q   <= s1_vld_d;
         y_q        <= y_d;
         cb_q       <= cb_d;
         cr_q       <= cr_d;
      end
   end

   assign in_ready_o = in_ready_q;

   // ****************************************************************
   // Scaled terms
   // ****************************************************************
   logic signed [TERM_W-1:0] term [ycrgb_pkg::N_TERMS];
   logic [IN_W-1:0]          code [ycrgb_pkg::N_TERMS];
   int                       ref_t [ycrgb_pkg::N_TERMS];

   for (genvar t = 0; t < ycrgb_pkg::N_TERMS; t++) begin : g_term
      localparam int OFF   = ycrgb_pkg::TERM_OFF[t];
      localparam int MILLI = ycrgb_pkg::TERM_COEF_MILLI[t];
      localparam logic [ycrgb_pkg::COEF_W-1:0] CQ =
         ycrgb_pkg::COEF_W'(ycrgb_pkg::coef_q(MILLI));

      if (ycrgb_pkg::TERM_SRC[t] == ycrgb_pkg::SRC_Y) begin : g_y
         assign code[t] = y_q;
      end else if (ycrgb_pkg::TERM_SRC[t] == ycrgb_pkg::SRC_CR) begin : g_cr
         assign code[t] = cr_q;
      end else begin : g_cb
         assign code[t] = cb_q;
      end

      if (USE_LUT) begin : g_lut
         ycrgb_term_rom #(
            .COEF_MILLI (MILLI),
            .OFFSET     (OFF)
         ) u_rom (
            .addr_i (code[t]),
            .data_o (term[t])
         );
      end else if (USE_TWOS) begin : g_twos
         logic signed [DIFF_W-1:0] diff;
         logic                     neg;
         logic [MAG_W-1:0]         mag;
         logic [PROD_W-1:0]        prod;
         logic signed [TERM_W-1:0] scaled;
         assign diff   = $signed({2'b00, code[t]}) - $signed(DIFF_W'(OFF));
         assign neg    = diff[DIFF_W-1];
         // Sign and magnitude let an unsigned multiply serve negative differences
         assign mag    = neg ? MAG_W'(-diff) : MAG_W'(diff);
         assign prod   = PROD_W'(mag) * PROD_W'(CQ);
         assign scaled = TERM_W'(prod >> SH);
         assign term[t] = neg ? -scaled : scaled;
      end else begin : g_signed
         logic signed [PROD_W-1:0] prods;
         // Inputs already hold the offset-removed value in two's complement
         assign prods   = PROD_W'($signed(code[t])) * $signed(PROD_W'(CQ));
         assign term[t] = TERM_W'(prods >>> SH);
      end

      // Reference in exact decimal for the checks below
      if (USE_LUT || USE_TWOS) begin : g_ref_off
         assign ref_t[t] = ((int'(code[t]) - OFF) * MILLI * (2 ** ycrgb_pkg::FRAC_W))
                           / ycrgb_pkg::MILLI;
      end else begin : g_ref_raw
         assign ref_t[t] = (int'($signed(code[t])) * MILLI * (2 ** ycrgb_pkg::FRAC_W))
                           / ycrgb_pkg::MILLI;
      end
   end

   // ****************************************************************
   // Output adders and saturation
   // ****************************************************************
   logic signed [SUM_W-1:0] r_sum;
   logic signed [SUM_W-1:0] g_sum;
   logic signed [SUM_W-1:0] b_sum;
   logic signed [SUM_W-1:0] t_luma;
   logic [OUT_W-1:0]        red_sat;
   logic [OUT_W-1:0]        green_sat;
   logic [OUT_W-1:0]        blue_sat;

   function automatic logic [OUT_W-1:0] sat_out(input logic signed [SUM_W-1:0] s);
      logic signed [SUM_W-1:0] w;
      w = s >>> ycrgb_pkg::FRAC_W;
      if (w < 0) begin
         return '0;
      end else if (w > ycrgb_pkg::SAT_HI) begin
         return ycrgb_pkg::OUT_MAX;
      end else begin
         return w[OUT_W-1:0];
      end
   endfunction

   // One luma product feeds all three adders
   assign t_luma = SUM_W'(term[ycrgb_pkg::T_LUMA]);

   always_comb begin
      r_sum = t_luma + SUM_W'(term[ycrgb_pkg::T_CR_R]);
      g_sum = t_luma - SUM_W'(term[ycrgb_pkg::T_CR_G])
                     - SUM_W'(term[ycrgb_pkg::T_CB_G]);
      b_sum = t_luma + SUM_W'(term[ycrgb_pkg::T_CB_B]);
      red_sat   = sat_out(r_sum);
      green_sat = sat_out(g_sum);
      blue_sat  = sat_out(b_sum);
   end

   // ****************************************************************
   // Two-entry output buffer, head entry drives the ports
   // ****************************************************************
   logic [OUT_W-1:0] red_q [ycrgb_pkg::BUF_DEPTH];
   logic [OUT_W-1:0] grn_q [ycrgb_pkg::BUF_DEPTH];
   logic [OUT_W-1:0] blu_q [ycrgb_pkg::BUF_DEPTH];
   logic [OUT_W-1:0] red_d [ycrgb_pkg::BUF_DEPTH];
   logic [OUT_W-1:0] grn_d [ycrgb_pkg::BUF_DEPTH];
   logic [OUT_W-1:0] blu_d [ycrgb_pkg::BUF_DEPTH];
   logic             out_valid_q, out_valid_d;
   logic [ycrgb_pkg::CNT_W-1:0] wr_pos;

   always_comb begin
      wr_pos = fcnt_q - (pop ? ONE : ZERO);
      fcnt_d = wr_pos + (push ? ONE : ZERO);
      for (int i = 0; i < ycrgb_pkg::BUF_DEPTH; i++) begin
         red_d[i] = red_q[i];
         grn_d[i] = grn_q[i];
         blu_d[i] = blu_q[i];
         if (pop && (i + 1 < ycrgb_pkg::BUF_DEPTH)) begin
            red_d[i] = red_q[i+1];
            grn_d[i] = grn_q[i+1];
            blu_d[i] = blu_q[i+1];
         end
         if (push && (wr_pos == ycrgb_pkg::CNT_W'(i))) begin
            red_d[i] = red_sat;
            grn_d[i] = green_sat;
            blu_d[i] = blue_sat;
         end
      end
      out_valid_d = (fcnt_d != ZERO);
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         fcnt_q      <= '0;
         out_valid_q <= 1'b0;
         for (int i = 0; i < ycrgb_pkg::BUF_DEPTH; i++) begin
            red_q[i] <= '0;
            grn_q[i] <= '0;
            blu_q[i] <= '0;
         end
      end else begin
         fcnt_q      <= fcnt_d;
         out_valid_q <= out_valid_d;
         for (int i = 0; i < ycrgb_pkg::BUF_DEPTH; i++) begin
            red_q[i] <= red_d[i];
            grn_q[i] <= grn_d[i];
            blu_q[i] <= blu_d[i];
         end
      end
   end

   assign out_valid_o = out_valid_q;
   assign red_o       = red_q[0];
   assign green_o     = grn_q[0];
   assign blue_o      = blu_q[0];

   // ****************************************************************
   // Checks
   // ****************************************************************
   localparam int TOL = 4;

   capture_in_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
      in_acc |=> s1_vld_q && y_q == $past(luma_i) && cb_q == $past(cb_i)
                 && cr_q == $past(cr_i))
      else $error("input word not captured");

   buf_load_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
      push && fcnt_q == ZERO |=> out_valid_o && red_o == $past(red_sat)
                 && green_o == $past(green_sat) && blue_o == $past(blue_sat))
      else $error("result not presented from buffer");

   buf_hold_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
      out_valid_o && !out_ready_i |=> out_valid_o && $stable(red_o)
                 && $stable(green_o) && $stable(blue_o))
      else $error("stalled output changed");

   luma_term_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
      s1_vld_q |-> int'(term[0]) - ref_t[0] <= TOL && ref_t[0] - int'(term[0]) <= TOL)
      else $error("luma term out of tolerance");

   cr_terms_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
      s1_vld_q |-> int'(term[1]) - ref_t[1] <= TOL && ref_t[1] - int'(term[1]) <= TOL
               && int'(term[2]) - ref_t[2] <= TOL && ref_t[2] - int'(term[2]) <= TOL)
      else $error("red-difference term out of tolerance");

   cb_terms_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
      s1_vld_q |-> int'(term[3]) - ref_t[3] <= TOL && ref_t[3] - int'(term[3]) <= TOL
               && int'(term[4]) - ref_t[4] <= TOL && ref_t[4] - int'(term[4]) <= TOL)
      else $error("blue-difference term out of tolerance");

   red_sum_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
      s1_vld_q |-> int'(r_sum) == int'(term[0]) + int'(term[1]))
      else $error("red sum wrong");

   green_sum_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
      s1_vld_q |-> int'(g_sum) == int'(term[0]) - int'(term[2]) - int'(term[3]))
      else $error("green sum wrong");

   blue_sum_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
      s1_vld_q |-> int'(b_sum) == int'(term[0]) + int'(term[4]))
      else $error("blue sum wrong");

   out_sat_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
      push && fcnt_q == ZERO && r_sum < 0 ##1 1'b1 |-> out_valid_o && red_o == '0)
      else $error("negative red sum not clamped to zero");

   buf_bound_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
      fcnt_q <= FULL && !(in_acc && s1_vld_q && !push))
      else $error("buffer overflow or word overwritten");

endmodule // ycrgb_converter

// ===== ycrgb_sink_model.sv
`timescale 1ns/100ps
// ****************************************************************
// Downstream pixel consumer: prompt, slow or fully stalled
// ****************************************************************
module ycrgb_sink_model (
   input  wire logic       core_clk_i,
   input  wire logic       srst_i,
   input  wire logic [1:0] mode_i,
   input  wire logic       out_valid_i,
   output logic            out_ready_o
);
   logic [1:0] tick_q;

   // Ready changes only just after an edge, like real pipeline logic
   always @(posedge core_clk_i) begin
      tick_q <= tick_q + 2'h1;
      if (srst_i) begin
         out_ready_o <= 1'b0;
         tick_q      <= 2'h0;
      end else begin
         case (mode_i)
            2'h0:    out_ready_o <= 1'b1;
            2'h1:    out_ready_o <= (tick_q == 2'h3);
            default: out_ready_o <= 1'b0;
         endcase
      end
   end
endmodule // ycrgb_sink_model

// ===== tb_top.sv
`timescale 1ns/100ps
module tb_top;
   logic        core_clk_i;
   logic        srst_i;
   logic        in_valid_i;
   logic [9:0]  luma_i, cb_i, cr_i;
   logic        in_ready_o, out_valid_o, out_ready_i, m_valid;
   logic [9:0]  red_o, green_o, blue_o, m_red, m_green, m_blue;
   logic [1:0]  sink_mode;
   logic [29:0] src_q[$];
   logic [29:0] exp_q[$];
   int          miscompares, checked, taken, take_cyc, cyc;
   bit          lat_chk;

   ycrgb_converter dut_u (.core_clk_i(core_clk_i), .srst_i(srst_i), .in_valid_i(in_valid_i),
      .in_ready_o(in_ready_o), .luma_i(luma_i), .cb_i(cb_i), .cr_i(cr_i),
      .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .red_o(red_o),
      .green_o(green_o), .blue_o(blue_o));
   // Multiplier variant runs in lockstep on the same stream
   ycrgb_converter #(.USE_LUT(1'b0), .USE_TWOS(1'b1)) mult_u (.core_clk_i(core_clk_i),
      .srst_i(srst_i), .in_valid_i(in_valid_i), .in_ready_o(), .luma_i(luma_i), .cb_i(cb_i),
      .cr_i(cr_i), .out_valid_o(m_valid), .out_ready_i(out_ready_i), .red_o(m_red),
      .green_o(m_green), .blue_o(m_blue));
   ycrgb_sink_model sink_u (.core_clk_i(core_clk_i), .srst_i(srst_i), .mode_i(sink_mode),
      .out_valid_i(out_valid_o), .out_ready_o(out_ready_i));

   // ****************************************************************
   // Reference arithmetic
   // ****************************************************************
   function automatic int term(int code, int milli, int off);
      int d, q, v;
      d = code - off;
      q = (milli * (2 ** ycrgb_pkg::COEF_SH) + ycrgb_pkg::MILLI / 2) / ycrgb_pkg::MILLI;
      v = (((d < 0) ? -d : d) * q) >>> (ycrgb_pkg::COEF_SH - ycrgb_pkg::FRAC_W);
      return (d < 0) ? -v : v;
   endfunction

   function automatic logic [9:0] sat(int s);
      s = s >>> ycrgb_pkg::FRAC_W;
      return (s < 0) ? 10'h000 : (s > 1023) ? 10'h3FF : 10'(s);
   endfunction

   function automatic logic [29:0] rgb_exp(logic [29:0] px);
      int l, cb, cr;
      cb = int'(px[19:10]);
      cr = int'(px[9:0]);
      l  = term(int'(px[29:20]), 1164, ycrgb_pkg::LUMA_OFF);
      return {sat(l + term(cr, 1596, 128)),
              sat(l - term(cr, 813, 128) - term(cb, 392, 128)),
              sat(l + term(cb, 2017, 128))};
   endfunction

   // ****************************************************************
   // Clock, source, monitor
   // ****************************************************************
   initial begin
      core_clk_i = 1'b0;
      forever #4 core_clk_i = ~core_clk_i;
   end

   always @(posedge core_clk_i) cyc <= cyc + 1;

   // Holds each word until taken, one word per cycle at full rate
   always @(posedge core_clk_i) begin
      if (in_valid_i && in_ready_o) begin
         void'(src_q.pop_front());
         taken++;
         take_cyc = cyc;
      end
      if (src_q.size() > 0) begin
         in_valid_i <= 1'b1;
         {luma_i, cb_i, cr_i} <= src_q[0];
      end else begin
         in_valid_i <= 1'b0;
      end
   end

   always @(posedge core_clk_i) begin
      if (out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
         logic [29:0] e;
         e = rgb_exp(exp_q.pop_front());
         chk({red_o, green_o, blue_o} === e, "lut result");
         chk(m_valid === 1'b1 && {m_red, m_green, m_blue} === e, "mul result");
         if (lat_chk) chk(cyc - take_cyc == 2, "latency");
      end
   end

   task automatic chk(bit ok, string msg);
      checked++;
      if (!ok) begin
         miscompares++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask

   task automatic push(logic [9:0] y, logic [9:0] cb, logic [9:0] cr);
      src_q.push_back({y, cb, cr});
      exp_q.push_back({y, cb, cr});
   endtask

   task automatic drain();
      int n;
      for (n = 0; n < 20000 && (src_q.size() > 0 || exp_q.size() > 0); n++)
         @(posedge core_clk_i);
      if (n == 20000) begin
         miscompares++;
         $display("[ERR] %0t stream stuck", $time);
         test_done();
      end
   endtask

   task automatic test_done();
      if (miscompares == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset();
      chk(out_valid_o === 1'b0 && in_ready_o === 1'b0, "reset flags");
      chk({red_o, green_o, blue_o} === 30'h0, "reset data");
   endtask

   task automatic t_latency();
      lat_chk = 1'b1;
      push(10'h064, 10'h0C8, 10'h032);
      drain();
      lat_chk = 1'b0;
   endtask

   // Black point, ceiling, floor and studio extremes back to back
   task automatic t_corners();
      push(10'h010, 10'h080, 10'h080);
      push(10'h3FF, 10'h3FF, 10'h3FF);
      push(10'h000, 10'h000, 10'h000);
      push(10'h0EB, 10'h0F0, 10'h010);
      push(10'h0EB, 10'h010, 10'h0F0);
      push(10'h200, 10'h07F, 10'h081);
      drain();
   endtask

   // Three words fill input register and buffer; the rest must wait
   task automatic t_stall();
      int base;
      base      = taken;
      sink_mode <= 2'h2;
      repeat (5) push(10'h150, 10'h0A0, 10'h170);
      repeat (12) @(posedge core_clk_i);
      chk(taken - base == 3, "in flight");
      chk(out_valid_o === 1'b1 && in_ready_o === 1'b0, "stall hold");
      sink_mode <= 2'h1;
      drain();
   endtask

   // Every table address of every term, with a slow consumer
   task automatic t_sweep();
      for (int i = 0; i < ycrgb_pkg::TBL_DEPTH; i++)
         push(10'(i), 10'(i), 10'(1023 - i));
      drain();
      sink_mode <= 2'h0;
   endtask

   initial begin
      srst_i      = 1'b1;
      in_valid_i  = 1'b0;
      {luma_i, cb_i, cr_i} = 30'h0;
      sink_mode   = 2'h0;
      miscompares = 0;
      checked     = 0;
      taken       = 0;
      cyc         = 0;
      lat_chk     = 1'b0;
      repeat (4) @(posedge core_clk_i);
      #1 t_reset();
      @(posedge core_clk_i);
      srst_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      t_latency();
      t_corners();
      t_stall();
      t_sweep();
      test_done();
   end
endmodule // tb_top
